// >>> include/gpp_pkg.sv
/*
 * Package for the eight-bit general-purpose port with parallel slave port and PWM pin override.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package gpp_pkg;
    localparam int GPP_WIDTH = 8;
    // Register byte offsets.
    localparam logic [7:0] GPP_OFS_PIN_LEVELS = 8'h00;
    localparam logic [7:0] GPP_OFS_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] GPP_OFS_DIRECTION = 8'h08;
    localparam logic [7:0] GPP_OFS_CONTROL_STATUS = 8'h0C;
    localparam logic [7:0] GPP_OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] GPP_OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] GPP_OFS_SLAVE_DATA = 8'h18;
    // Control/status field positions.
    localparam int GPP_BIT_INPUT_FULL = 7;
    localparam int GPP_BIT_OUTPUT_FULL = 6;
    localparam int GPP_BIT_INPUT_OVERFLOW = 5;
    localparam int GPP_BIT_SLAVE_MODE = 4;
    // Interrupt status bits.
    localparam int GPP_IRQ_WRITE = 0;
    localparam int GPP_IRQ_READ = 1;
    localparam int GPP_IRQ_OVERFLOW = 2;
    localparam int GPP_IRQ_BITS = 3;
    // Reset values.
    localparam logic [7:0] GPP_RST_DIRECTION = 8'hFF;
    localparam logic [7:0] GPP_RST_LATCH = 8'h00;
    localparam logic [7:0] GPP_RST_CONTROL = 8'h00;
    // Writable mask of the control/status register.
    localparam logic [7:0] GPP_CTRL_WMASK = 8'h30;
    // Lowest pin that carries a PWM channel.
    localparam int GPP_PWM_FIRST_PIN = 5;
    localparam int GPP_SYNC_STAGES = 3;
    localparam logic [1:0] GPP_HTRANS_NONSEQ = 2'h2;
endpackage

// >>> core/gpp_port.sv
/*
 * Eight-bit bidirectional port with AHB-Lite registers, parallel slave port data path,
 * and PWM channel override on the three upper pins.
 * Assumes pins, slave-port strobes and shutdown arrive asynchronously, PWM levels arrive on hclk.
 */
// Register access over AHB-Lite and the address map were chosen for this implementation.
// Behaviour
// - Eight pins, each with data, direction and output latch bits.
// - Direction bit one disables the pin driver, pin is input.
// - Direction bit zero drives the pin from its latch bit.
// - Each pin direction set independently.
// - Latch register reads and writes the latch, not the pins.
// - Port data read returns synchronised pin levels, or the received word in slave port mode.
// - After reset all pins are inputs.
// - Mode bit four of control register selects parallel slave port.
// - Slave port mode selects TTL input thresholds.
// - During external read pins drive latch, ignoring direction.
// - External writes accepted on all pins regardless of direction.
// - Dual or quad PWM output disables slave port functions; here the mode bit alone still lets latch writes set output-full.
// - PWM channels B, C, D on pins 5-7 override all data on pins whose direction bit is clear.
// - PWM pins go high impedance on shutdown when so configured.
// - Unimplemented control bits read zero.
// - Input-full after external write; output-full while written word unread.
// - Overflow set when writing before previous read; software clears it.
`timescale 1ns/1ns
module gpp_port
    import gpp_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port pins.
    input wire logic [gpp_pkg::GPP_WIDTH-1:0] pin_in,
    output logic [gpp_pkg::GPP_WIDTH-1:0] pin_out,
    output logic [gpp_pkg::GPP_WIDTH-1:0] pin_oe,
    output logic ttl_select,
    // Parallel slave port strobes from the external processor, active low.
    input wire logic ext_read_n,
    input wire logic ext_write_n,
    input wire logic ext_select_n,
    // PWM unit.
    input wire logic [2:0] pwm_level,
    input wire logic pwm_active,
    input wire logic pwm_multi_output,
    input wire logic pwm_shutdown,
    input wire logic pwm_tristate_on_shutdown,
    // Interrupt.
    output logic irq
);
    import gpp_pkg::*;

    function automatic logic [2:0] sync_agree(input logic [2:0] s);
        // Returns the shifted stage chain; a change counts once stages two and three agree.
        sync_agree = s;
    endfunction

    // Addresses whose read hands the received slave-port word to software.
    function automatic logic rx_word_addr(input logic [7:0] a);
        rx_word_addr = (a == GPP_OFS_PIN_LEVELS) || (a == GPP_OFS_SLAVE_DATA);
    endfunction

    // Pin and strobe synchronisers: three stages each.
    logic [GPP_WIDTH-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;
    logic [2:0] stb_s1_q, stb_s2_q, stb_s3_q, stb_lvl_q, stb_lvl_d;
    logic shd_s1_q, shd_s2_q, shd_s3_q, shd_lvl_q, shd_lvl_d;

    always_comb begin
        pin_lvl_d = pin_lvl_q;
        for (int i = 0; i < GPP_WIDTH; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
                pin_lvl_d[i] = pin_s3_q[i];
            end
        end
        stb_lvl_d = stb_lvl_q;
        for (int i = 0; i < 3; i++) begin
            if (stb_s2_q[i] == stb_s3_q[i]) begin
                stb_lvl_d[i] = stb_s3_q[i];
            end
        end
        shd_lvl_d = (shd_s2_q == shd_s3_q) ? shd_s3_q : shd_lvl_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
            pin_lvl_q <= 8'h00;
            stb_s1_q <= 3'h7;
            stb_s2_q <= 3'h7;
            stb_s3_q <= 3'h7;
            stb_lvl_q <= 3'h7;
            shd_s1_q <= 1'b0;
            shd_s2_q <= 1'b0;
            shd_s3_q <= 1'b0;
            shd_lvl_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_lvl_q <= pin_lvl_d;
            stb_s1_q <= {ext_select_n, ext_write_n, ext_read_n};
            stb_s2_q <= stb_s1_q;
            stb_s3_q <= sync_agree(stb_s2_q);
            stb_lvl_q <= stb_lvl_d;
            shd_s1_q <= pwm_shutdown;
            shd_s2_q <= shd_s1_q;
            shd_s3_q <= shd_s2_q;
            shd_lvl_q <= shd_lvl_d;
        end
    end

    // Slave port mode is only live while the PWM unit is not using several outputs.
    logic mode_q, mode_d;
    logic slave_on;
    assign slave_on = mode_q && !pwm_multi_output;

    // External strobes, active while select and read/write are both low.
    logic ext_rd, ext_wr, ext_wr_prev_q, ext_rd_prev_q;
    assign ext_rd = slave_on && !stb_lvl_q[2] && !stb_lvl_q[0];
    assign ext_wr = slave_on && !stb_lvl_q[2] && !stb_lvl_q[1];
    logic ext_wr_end, ext_rd_end;
    // Data is captured at the end of the strobe, when the external bus has settled.
    assign ext_wr_end = ext_wr_prev_q && !ext_wr;
    assign ext_rd_end = ext_rd_prev_q && !ext_rd;

    // AHB address phase capture.
    logic ap_valid_q, ap_write_q;
    logic [7:0] ap_addr_q;
    logic ap_take;
    assign ap_take = hsel && hready && (htrans == GPP_HTRANS_NONSEQ);

    logic bus_wr, bus_rd;
    assign bus_wr = ap_valid_q && ap_write_q;
    assign bus_rd = ap_take && !hwrite;
    logic latch_wr;
    assign latch_wr = bus_wr && (ap_addr_q == GPP_OFS_PIN_LEVELS || ap_addr_q == GPP_OFS_OUTPUT_LATCH);

    // Registers.
    logic [7:0] latch_q, latch_d, dir_q, dir_d, in_word_q, in_word_d;
    logic ibf_q, ibf_d, obf_q, obf_d, input_overflow_flag_q, input_overflow_flag_d;
    logic [GPP_IRQ_BITS-1:0] ist_q, ist_d, imask_q, imask_d;
    logic [7:0] wbyte;
    assign wbyte = hwdata[7:0];

    always_comb begin
        latch_d = latch_q;
        dir_d = dir_q;
        mode_d = mode_q;
        in_word_d = in_word_q;
        ibf_d = ibf_q;
        obf_d = obf_q;
        input_overflow_flag_d = input_overflow_flag_q;
        imask_d = imask_q;
        ist_d = ist_q;
        if (bus_wr) begin
            unique case (ap_addr_q)
                GPP_OFS_PIN_LEVELS, GPP_OFS_OUTPUT_LATCH: begin
                    latch_d = wbyte;
                    if (mode_q) begin
                        obf_d = 1'b1;
                    end
                end
                GPP_OFS_DIRECTION: dir_d = wbyte;
                GPP_OFS_CONTROL_STATUS: begin
                    mode_d = wbyte[GPP_BIT_SLAVE_MODE];
                    if (!wbyte[GPP_BIT_INPUT_OVERFLOW]) begin
                        input_overflow_flag_d = 1'b0;
                    end
                end
                GPP_OFS_IRQ_STATUS: ist_d = ist_q & ~wbyte[GPP_IRQ_BITS-1:0];
                GPP_OFS_IRQ_MASK: imask_d = wbyte[GPP_IRQ_BITS-1:0];
                default: ;
            endcase
        end
        // Reading the received word releases the input-full flag.
        if (bus_rd && rx_word_addr(haddr) && mode_q) begin
            ibf_d = 1'b0;
        end
        // Hardware sets win over software clears below.
        if (ext_wr_end) begin
            in_word_d = pin_lvl_q;
            if (ibf_q && !(bus_rd && rx_word_addr(haddr))) begin
                input_overflow_flag_d = 1'b1;
                ist_d[GPP_IRQ_OVERFLOW] = 1'b1;
            end
            ibf_d = 1'b1;
            ist_d[GPP_IRQ_WRITE] = 1'b1;
        end
        if (ext_rd_end) begin
            // A word written by software in the same cycle is still unread, so its set wins.
            if (!(latch_wr && mode_q)) begin
                obf_d = 1'b0;
            end
            ist_d[GPP_IRQ_READ] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= GPP_RST_LATCH;
            dir_q <= GPP_RST_DIRECTION;
            mode_q <= 1'b0;
            in_word_q <= 8'h00;
            ibf_q <= 1'b0;
            obf_q <= 1'b0;
            input_overflow_flag_q <= 1'b0;
            ist_q <= 3'h0;
            imask_q <= 3'h0;
            ext_wr_prev_q <= 1'b0;
            ext_rd_prev_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            mode_q <= mode_d;
            in_word_q <= in_word_d;
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            input_overflow_flag_q <= input_overflow_flag_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            ext_wr_prev_q <= ext_wr;
            ext_rd_prev_q <= ext_rd;
        end
    end

    // Bus slave: zero wait states, always OKAY.
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (haddr)
            GPP_OFS_PIN_LEVELS: rdata_d[7:0] = slave_on ? in_word_q : pin_lvl_q;
            GPP_OFS_OUTPUT_LATCH: rdata_d[7:0] = latch_q;
            GPP_OFS_DIRECTION: rdata_d[7:0] = dir_q;
            // Bit three and the low direction bits of the neighbouring port are not held here.
            GPP_OFS_CONTROL_STATUS: rdata_d[7:0] = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 4'h0};
            GPP_OFS_IRQ_STATUS: rdata_d[GPP_IRQ_BITS-1:0] = ist_q;
            GPP_OFS_IRQ_MASK: rdata_d[GPP_IRQ_BITS-1:0] = imask_q;
            GPP_OFS_SLAVE_DATA: rdata_d[7:0] = in_word_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite;
            ap_addr_q <= haddr;
            if (bus_rd) begin
                hrdata <= rdata_d;
            end
        end
    end

    // Pin drivers.
    logic [7:0] pout_d, poe_d;
    always_comb begin
        for (int i = 0; i < GPP_WIDTH; i++) begin
            pout_d[i] = latch_q[i];
            poe_d[i] = !dir_q[i];
            if (slave_on) begin
                // Driven only during an external read, direction bits ignored.
                poe_d[i] = ext_rd;
            end
        end
        for (int i = GPP_PWM_FIRST_PIN; i < GPP_WIDTH; i++) begin
            // Relies on software having cleared the direction bit first.
            if (pwm_active && !dir_q[i]) begin
                pout_d[i] = pwm_level[i-GPP_PWM_FIRST_PIN];
                poe_d[i] = !(shd_lvl_q && pwm_tristate_on_shutdown);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            ttl_select <= 1'b0;
            irq <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            pin_out <= pout_d;
            pin_oe <= poe_d;
            ttl_select <= slave_on;
            irq <= |(ist_d & imask_d);
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    direction_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!slave_on && !pwm_active && dir_q == 8'hFF) |=> pin_oe == 8'h00)
        else $error("Pin driven while all directions are input.");
    latch_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!slave_on && !pwm_active) |=> pin_out == $past(latch_q))
        else $error("Pin output does not follow latch.");
    pin_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!slave_on && !pwm_active) |=> pin_oe == ~$past(dir_q))
        else $error("Pin enable does not follow direction.");
    data_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_wr && ap_addr_q == GPP_OFS_PIN_LEVELS) |=> latch_q == $past(wbyte))
        else $error("Port data write missed latch.");
    latch_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_wr && ap_addr_q == GPP_OFS_OUTPUT_LATCH) |=> latch_q == $past(wbyte))
        else $error("Latch write missed latch.");
    latch_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_rd && haddr == GPP_OFS_OUTPUT_LATCH) |=> hrdata[7:0] == $past(latch_q))
        else $error("Latch read does not return latch.");
    pin_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_rd && haddr == GPP_OFS_PIN_LEVELS && !slave_on) |=> hrdata[7:0] == $past(pin_lvl_q))
        else $error("Port read does not return pin levels.");
    dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_wr && ap_addr_q == GPP_OFS_DIRECTION) |=> dir_q == $past(wbyte))
        else $error("Direction write missed.");
    mode_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_wr && ap_addr_q == GPP_OFS_CONTROL_STATUS) |=> mode_q == $past(wbyte[GPP_BIT_SLAVE_MODE]))
        else $error("Mode bit write missed.");
    ttl_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ttl_select == $past(slave_on))
        else $error("Input threshold select does not follow mode.");
    unimpl_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_rd && haddr == GPP_OFS_CONTROL_STATUS) |=> hrdata[3:0] == 4'h0 && hrdata[31:8] == 24'h0)
        else $error("Unimplemented control bits not zero.");
    ibf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_wr_end |=> ibf_q && in_word_q == $past(pin_lvl_q))
        else $error("External write not captured.");
    ist_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_wr_end |=> ist_q[GPP_IRQ_WRITE])
        else $error("External write event not recorded.");
    word_read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_rd && rx_word_addr(haddr) && mode_q && !ext_wr_end) |=> !ibf_q)
        else $error("Input full not released by read.");
    slave_data_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_rd && haddr == GPP_OFS_SLAVE_DATA) |=> hrdata[7:0] == $past(in_word_q))
        else $error("Received word read wrong.");
    obf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (latch_wr && mode_q) |=> obf_q)
        else $error("Output full not set by latch write.");
    obf_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_rd_end && !latch_wr) |=> !obf_q)
        else $error("Output full not cleared by external read.");
    overflow_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_wr_end && ibf_q && !bus_rd) |=> input_overflow_flag_q)
        else $error("Overflow not flagged.");
    input_overflow_flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (bus_wr && ap_addr_q == GPP_OFS_CONTROL_STATUS && !wbyte[GPP_BIT_INPUT_OVERFLOW] && !ext_wr_end) |=> !input_overflow_flag_q)
        else $error("Overflow not cleared by software.");
    slave_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_rd |=> pin_oe == 8'hFF || pwm_active)
        else $error("Slave read not driving pins.");
    slave_read_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ext_rd && !pwm_active) |=> pin_out == $past(latch_q))
        else $error("Slave read not driving latch.");
    slave_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (slave_on && !ext_rd && !pwm_active) |=> pin_oe == 8'h00)
        else $error("Slave port driving outside a read.");
    pwm_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_multi_output |=> !ttl_select)
        else $error("Slave port live during multi-output PWM.");
    pwm_override_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_active && dir_q[7:5] == 3'h0) |=> pin_out[7:5] == $past(pwm_level))
        else $error("PWM level not on its pins.");
    shutdown_tri_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_active && shd_lvl_q && pwm_tristate_on_shutdown) |=> pin_oe[7:5] == 3'h0)
        else $error("PWM pin driven during shutdown.");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(ist_q & imask_q)) |-> ##[0:1] irq)
        else $error("Interrupt not raised.");
    irq_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(ist_q & imask_q)) |-> !irq)
        else $error("Interrupt raised with no unmasked event.");
endmodule

// >>> testbench/gpp_ext_model.sv
/*
 * Model of the far side of the port: the external pin drivers and the external processor.
 * Assumes the device pins resolve with the device driver winning where its output enable is high.
 */
`timescale 1ns/1ns
module gpp_ext_model (
    // Clock.
    input wire logic hclk,
    // Device side of the pins.
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_in,
    // Processor strobes, active low.
    output logic ext_read_n,
    output logic ext_write_n,
    output logic ext_select_n
);
    logic [7:0] drv_val = 8'h00;
    logic [7:0] drv_en = 8'h00;
    logic [7:0] last_q = 8'h00;
    initial begin
        ext_read_n = 1'b1;
        ext_write_n = 1'b1;
        ext_select_n = 1'b1;
    end
    // Floating pins show the inverse of their last level, so stale data can never look valid.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & ~last_q);
    // Only driven bits refresh the remembered level, so a floating bit holds steady at the inverse.
    always @(posedge hclk) begin
        last_q <= ((pin_oe | drv_en) & pin_in) | (~(pin_oe | drv_en) & last_q);
    end
    task automatic drive(input logic [7:0] v, input logic [7:0] en);
        drv_val <= v;
        drv_en <= en;
    endtask
    // The processor puts a word on all eight pins and strobes it in.
    task automatic write_word(input logic [7:0] v);
        drive(v, 8'hFF);
        @(posedge hclk);
        ext_select_n <= 1'b0;
        ext_write_n <= 1'b0;
        repeat (6) @(posedge hclk);
        ext_write_n <= 1'b1;
        ext_select_n <= 1'b1;
        repeat (2) @(posedge hclk);
        drv_en <= 8'h00;
        repeat (8) @(posedge hclk);
    endtask
    task automatic read_strobe(input logic on);
        ext_read_n <= ~on;
        ext_select_n <= ~on;
    endtask
endmodule

// >>> testbench/tb.sv
/*
 * Self-checking bench for the eight-bit port: registers over AHB-Lite, pins, slave port and PWM.
 * Assumes zero-wait-state bus answers and about four cycles of strobe and pin synchronisation.
 */
`timescale 1ns/1ns
module tb;
    import gpp_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hsel = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic sel_en = 1'b1;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ttl_select, irq, ext_read_n, ext_write_n, ext_select_n;
    logic [7:0] pin_in, pin_out, pin_oe;
    logic [2:0] pwm_level = 3'h0;
    logic pwm_active = 1'b0;
    logic pwm_multi_output = 1'b0;
    logic pwm_shutdown = 1'b0;
    logic pwm_tristate_on_shutdown = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] r;
    always #25 hclk = ~hclk;
    gpp_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ttl_select(ttl_select), .ext_read_n(ext_read_n), .ext_write_n(ext_write_n),
        .ext_select_n(ext_select_n), .pwm_level(pwm_level), .pwm_active(pwm_active),
        .pwm_multi_output(pwm_multi_output), .pwm_shutdown(pwm_shutdown),
        .pwm_tristate_on_shutdown(pwm_tristate_on_shutdown), .irq(irq));
    gpp_ext_model p (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_read_n(ext_read_n), .ext_write_n(ext_write_n), .ext_select_n(ext_select_n));
    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for the next edge with hready high; a hung slave ends the run.
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        htrans <= GPP_HTRANS_NONSEQ;
        hsel <= sel_en;
        hsize <= 3'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hsize <= 3'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, {24'h0, d}, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic t_reset;
        rd_chk(GPP_OFS_DIRECTION, 32'hFF);
        sel_en = 1'b0;
        wr(GPP_OFS_OUTPUT_LATCH, 8'hFF);
        sel_en = 1'b1;
        rd_chk(GPP_OFS_OUTPUT_LATCH, 32'h00);
        rd_chk(8'h40, 32'h00);
        chk(pin_oe, 8'h00);
    endtask
    task automatic t_gpio;
        wr(GPP_OFS_OUTPUT_LATCH, 8'h5A);
        wr(GPP_OFS_DIRECTION, 8'hF0);
        repeat (2) @(posedge hclk);
        chk(pin_oe, 8'h0F);
        chk(pin_out[3:0], 4'hA);
        p.drive(8'hA5, 8'hF0);
        repeat (8) @(posedge hclk);
        rd_chk(GPP_OFS_OUTPUT_LATCH, 32'h5A);
        rd_chk(GPP_OFS_PIN_LEVELS, 32'hAA);
        wr(GPP_OFS_PIN_LEVELS, 8'h33);
        rd_chk(GPP_OFS_OUTPUT_LATCH, 32'h33);
        p.drive(8'h00, 8'h00);
    endtask
    task automatic t_slave_write;
        wr(GPP_OFS_DIRECTION, 8'h00);
        wr(GPP_OFS_CONTROL_STATUS, 8'hFF);
        wr(GPP_OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h10);
        chk(ttl_select, 1'b1);
        chk(pin_oe, 8'h00);
        p.write_word(8'h3C);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h90);
        chk(irq, 1'b1);
        wr(GPP_OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        rd_chk(GPP_OFS_SLAVE_DATA, 32'h3C);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h10);
        p.write_word(8'hC3);
        p.write_word(8'h81);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'hB0);
        wr(GPP_OFS_CONTROL_STATUS, 8'h10);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h90);
        rd_chk(GPP_OFS_PIN_LEVELS, 32'h81);
        wr(GPP_OFS_IRQ_STATUS, 8'h07);
    endtask
    task automatic t_slave_read;
        wr(GPP_OFS_OUTPUT_LATCH, 8'h96);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h50);
        wr(GPP_OFS_DIRECTION, 8'hFF);
        p.read_strobe(1'b1);
        repeat (8) @(posedge hclk);
        chk(pin_oe, 8'hFF);
        chk(pin_out, 8'h96);
        p.read_strobe(1'b0);
        repeat (8) @(posedge hclk);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h10);
        rd_chk(GPP_OFS_IRQ_STATUS, 32'h02);
    endtask
    task automatic t_pwm;
        logic [31:0] q;
        wr(GPP_OFS_CONTROL_STATUS, 8'h00);
        wr(GPP_OFS_DIRECTION, 8'h00);
        pwm_active <= 1'b1;
        pwm_level <= 3'h3;
        repeat (3) @(posedge hclk);
        chk(pin_out, 8'h76);
        pwm_shutdown <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(pin_oe, 8'hFF);
        pwm_tristate_on_shutdown <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(pin_oe, 8'h1F);
        pwm_shutdown <= 1'b0;
        pwm_multi_output <= 1'b1;
        wr(GPP_OFS_DIRECTION, 8'hFF);
        wr(GPP_OFS_CONTROL_STATUS, 8'h10);
        p.write_word(8'h55);
        bus(GPP_OFS_CONTROL_STATUS, 1'b0, 32'h0, q);
        chk(q & 32'h80, 32'h00);
        chk(ttl_select, 1'b0);
    endtask
    task automatic t_rerun;
        pwm_active <= 1'b0;
        wr(GPP_OFS_DIRECTION, 8'h00);
        repeat (2) @(posedge hclk);
        chk(pin_oe, 8'hFF);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(pin_oe, 8'h00);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(GPP_OFS_DIRECTION, 32'hFF);
        rd_chk(GPP_OFS_CONTROL_STATUS, 32'h00);
        rd_chk(GPP_OFS_IRQ_STATUS, 32'h00);
        rd_chk(GPP_OFS_IRQ_MASK, 32'h00);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_gpio();
        t_slave_write();
        t_slave_read();
        t_pwm();
        t_rerun();
        close_out();
    end
endmodule
